// file: cfcs_can_fieldbus_command_status.sv
// Design: CAN fieldbus command word, speed reference and status counters
`default_nettype none
module cfcs_can_fieldbus_command_status
    import cfcs_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    // Writes from the CAN protocol engine
    input wire logic canCmdWrite,
    input wire logic [7:0] canCmdData,
    input wire logic canSpeedWrite,
    input wire logic [15:0] canSpeedData,
    // Writes from any other source (keypad, serial, soft PLC)
    input wire logic otherCmdWrite,
    input wire logic otherSpeedWrite,
    input wire logic [15:0] otherWriteData,
    // Drive configuration
    input wire logic commandSourceIsCan,
    input wire logic referenceSourceIsCan,
    input wire logic directionCommandBitSource,
    input wire logic [1:0] canProtocolSelect,
    // Controller conditions
    input wire logic autobaudRunning,
    input wire logic warningLevel,
    input wire logic errorPassive,
    input wire logic busOff,
    input wire logic noBusPower,
    // Frame events, one-cycle pulses
    input wire logic frameReceived,
    input wire logic frameTransmitted,
    input wire logic frameLost,
    // Protocol state inputs
    input wire logic coErrorControl,
    input wire logic coGuardError,
    input wire logic coHeartbeatError,
    input wire logic [2:0] coNodeStateIn,
    input wire logic dnOnline,
    input wire logic dnConnected,
    input wire logic dnTimedOut,
    input wire logic dnLinkFailure,
    // Register views
    output logic [7:0] fieldbusCommandWord,
    output logic [15:0] fieldbusSpeedReference,
    output logic [2:0] controllerStatus,
    output logic [2:0] canopenCommStatus,
    output logic [2:0] canopenNodeState,
    output logic [2:0] devicenetStatus,
    output logic [CNT_W-1:0] rxFrameCount,
    output logic [CNT_W-1:0] txFrameCount,
    output logic [CNT_W-1:0] busOffCount,
    output logic [CNT_W-1:0] lostMessageCount,
    // Commands to motor control
    output logic rampEnable,
    output logic generalEnable,
    output logic runReverse,
    output logic inchingRun,
    output logic remoteSetSelect,
    output logic secondRampSelect,
    output logic quickStopDisable,
    output logic faultResetPulse,
    output logic [15:0] activeSpeedReference,
    output logic motorForward
);
    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    // Counters wider than the sixteen-bit register view could not be read back whole
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
        $error("CNT_W must lie between 1 and 16");
    end

    // ----------------------------------------
    // Write decoding
    // ----------------------------------------
    // Other sources have no write path at all, so their strobes go nowhere
    wire logic cmdLoad = canCmdWrite;
    wire logic speedLoad = canSpeedWrite;
    wire logic signed [15:0] speedIn = $signed(canSpeedData);
    // Out-of-range references saturate rather than wrap, so a bad frame cannot flip sign
    wire logic speedTooHigh = (speedIn > SPEED_MAX);
    wire logic speedTooLow = (speedIn < SPEED_MIN);
    wire logic signed [15:0] speedClamped = speedTooHigh ? SPEED_MAX :
        speedTooLow ? SPEED_MIN : speedIn;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            fieldbusCommandWord <= CMD_RESET;
        end else if (cmdLoad) begin
            fieldbusCommandWord <= canCmdData;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            fieldbusSpeedReference <= SPEED_RESET;
        end else if (speedLoad) begin
            fieldbusSpeedReference <= speedClamped;
        end
    end

    // ----------------------------------------
    // Command execution
    // ----------------------------------------
    // Bits are held while another source commands, but not executed
    wire logic [7:0] cmdExec = commandSourceIsCan ? fieldbusCommandWord : CMD_RESET;
    logic faultBitPrev;
    // Edge of the gated bit, so handing command to CAN with bit 7 set also resets
    wire logic faultRise = cmdExec[CMD_FAULT_RESET] & ~faultBitPrev;
    wire logic next_rampEnable = cmdExec[CMD_RAMP_ENABLE];
    wire logic next_generalEnable = cmdExec[CMD_GENERAL_ENABLE];
    wire logic next_runReverse = cmdExec[CMD_RUN_REVERSE];
    wire logic next_inchingRun = cmdExec[CMD_INCHING];
    wire logic next_remoteSetSelect = cmdExec[CMD_REMOTE_SET];
    wire logic next_secondRampSelect = cmdExec[CMD_SECOND_RAMP];
    wire logic next_quickStopDisable = cmdExec[CMD_NO_QUICK_STOP];

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            faultBitPrev <= 1'b0;
            faultResetPulse <= 1'b0;
        end else begin
            faultBitPrev <= cmdExec[CMD_FAULT_RESET];
            faultResetPulse <= faultRise;
        end
    end

    // Motion commands
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rampEnable <= 1'b0;
            generalEnable <= 1'b0;
            runReverse <= 1'b0;
            inchingRun <= 1'b0;
        end else begin
            rampEnable <= next_rampEnable;
            generalEnable <= next_generalEnable;
            runReverse <= next_runReverse;
            inchingRun <= next_inchingRun;
        end
    end

    // Mode selects
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            remoteSetSelect <= 1'b0;
            secondRampSelect <= 1'b0;
            quickStopDisable <= 1'b0;
        end else begin
            remoteSetSelect <= next_remoteSetSelect;
            secondRampSelect <= next_secondRampSelect;
            quickStopDisable <= next_quickStopDisable;
        end
    end

    // ----------------------------------------
    // Speed reference and direction
    // ----------------------------------------
    // A reference not in use reads as zero, so a change of source brings the motor to rest
    wire logic [15:0] speedUsed = referenceSourceIsCan ? fieldbusSpeedReference : 16'h0000;
    wire logic speedPositive = ~speedUsed[15] & (speedUsed != 16'h0000);
    wire logic speedNegative = speedUsed[15];

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            activeSpeedReference <= SPEED_RESET;
        end else begin
            activeSpeedReference <= speedUsed;
        end
    end

    // ----------------------------------------
    // Direction
    // ----------------------------------------
    // Zero reference keeps the previous direction to avoid chatter
    wire logic next_motorForward = (directionCommandBitSource & speedPositive) |
        (~directionCommandBitSource & speedNegative);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            motorForward <= 1'b1;
        end else if (speedPositive | speedNegative) begin
            motorForward <= next_motorForward;
        end
    end

    // ----------------------------------------
    // Controller and protocol status
    // ----------------------------------------
    wire logic protoNone = (canProtocolSelect == PROTO_NONE);
    wire logic protoDnet = (canProtocolSelect == PROTO_DNET);
    wire logic protoCo = (canProtocolSelect == PROTO_CANOPEN);
    wire logic ctlAutobaud = protoDnet & autobaudRunning;
    // Worse conditions take precedence: power, bus off, passive, warning
    wire cfcs_ctl_type next_controllerStatus =
        protoNone ? CTL_DISABLED :
        noBusPower ? CTL_NO_POWER :
        busOff ? CTL_BUS_OFF :
        errorPassive ? CTL_PASSIVE :
        warningLevel ? CTL_WARNING :
        ctlAutobaud ? CTL_AUTOBAUD : CTL_ACTIVE;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            controllerStatus <= 3'(CTL_DISABLED);
        end else begin
            controllerStatus <= next_controllerStatus;
        end
    end

    // ----------------------------------------
    // Protocol status
    // ----------------------------------------
    wire cfcs_comm_type next_canopenCommStatus =
        !protoCo ? CO_INACTIVE :
        coHeartbeatError ? CO_HEART_ERR :
        coGuardError ? CO_GUARD_ERR :
        coErrorControl ? CO_ERR_CTRL : CO_ENABLED;

    wire logic nodeValid = (coNodeStateIn <= 3'(NODE_PREOP));
    wire logic [2:0] next_canopenNodeState =
        (protoCo & nodeValid) ? coNodeStateIn : 3'(NODE_INACTIVE);

    wire cfcs_dnet_type next_devicenetStatus =
        !protoDnet ? DN_OFFLINE :
        autobaudRunning ? DN_AUTOBAUD :
        (dnLinkFailure | busOff) ? DN_LINK_FAIL :
        dnTimedOut ? DN_TIMEOUT :
        dnConnected ? DN_CONNECTED :
        dnOnline ? DN_ONLINE : DN_OFFLINE;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            canopenCommStatus <= 3'(CO_INACTIVE);
        end else begin
            canopenCommStatus <= next_canopenCommStatus;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            canopenNodeState <= 3'(NODE_INACTIVE);
        end else begin
            canopenNodeState <= next_canopenNodeState;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            devicenetStatus <= 3'(DN_OFFLINE);
        end else begin
            devicenetStatus <= next_devicenetStatus;
        end
    end

    // ----------------------------------------
    // Event counters
    // ----------------------------------------
    logic busOffPrev;
    // A bus off that persists counts once, on entry
    wire logic busOffEntry = busOff & ~busOffPrev;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            busOffPrev <= 1'b0;
        end else begin
            busOffPrev <= busOff;
        end
    end

    // Natural binary wrap returns each counter to zero after its maximum
    wire logic [CNT_W-1:0] next_rxFrameCount = rxFrameCount + CNT_W'(1);
    wire logic [CNT_W-1:0] next_txFrameCount = txFrameCount + CNT_W'(1);
    wire logic [CNT_W-1:0] next_busOffCount = busOffCount + CNT_W'(1);
    wire logic [CNT_W-1:0] next_lostMessageCount = lostMessageCount + CNT_W'(1);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rxFrameCount <= CNT_W'(COUNT_RESET);
        end else if (frameReceived) begin
            rxFrameCount <= next_rxFrameCount;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            txFrameCount <= CNT_W'(COUNT_RESET);
        end else if (frameTransmitted) begin
            txFrameCount <= next_txFrameCount;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            busOffCount <= CNT_W'(COUNT_RESET);
        end else if (busOffEntry) begin
            busOffCount <= next_busOffCount;
        end
    end

    // Rapid growth here means the bit rate is too high for the node
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            lostMessageCount <= CNT_W'(COUNT_RESET);
        end else if (frameLost) begin
            lostMessageCount <= next_lostMessageCount;
        end
    end

    // ----------------------------------------
    // Other write sources
    // ----------------------------------------
    // Kept as ports so every access path is visible; none of them reaches storage
    wire logic unusedOther = otherCmdWrite | otherSpeedWrite | (|otherWriteData);
endmodule : cfcs_can_fieldbus_command_status
`default_nettype wire

// file: cfcs_pkg.sv
// Package: constants for the CAN fieldbus command and status block
`default_nettype none
package cfcs_pkg;
    // ----------------------------------------
    // Command word bit positions
    // ----------------------------------------
    localparam int CMD_RAMP_ENABLE = 0;
    localparam int CMD_GENERAL_ENABLE = 1;
    localparam int CMD_RUN_REVERSE = 2;
    localparam int CMD_INCHING = 3;
    localparam int CMD_REMOTE_SET = 4;
    localparam int CMD_SECOND_RAMP = 5;
    localparam int CMD_NO_QUICK_STOP = 6;
    localparam int CMD_FAULT_RESET = 7;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [15:0] SPEED_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // Speed reference in hundredths of a percent
    localparam logic signed [15:0] SPEED_MAX = 16'sd20000;
    localparam logic signed [15:0] SPEED_MIN = -16'sd20000;
    localparam logic signed [15:0] SPEED_FULL_SCALE = 16'sd10000;

    // ----------------------------------------
    // Status encodings
    // ----------------------------------------
    typedef enum logic [2:0] {
        CTL_DISABLED = 3'b000, CTL_AUTOBAUD = 3'b001, CTL_ACTIVE = 3'b010,
        CTL_WARNING = 3'b011, CTL_PASSIVE = 3'b100, CTL_BUS_OFF = 3'b101,
        CTL_NO_POWER = 3'b110
    } cfcs_ctl_type;
    typedef enum logic [2:0] {
        CO_INACTIVE = 3'b000, CO_ENABLED = 3'b010, CO_ERR_CTRL = 3'b011,
        CO_GUARD_ERR = 3'b100, CO_HEART_ERR = 3'b101
    } cfcs_comm_type;
    typedef enum logic [2:0] {
        NODE_INACTIVE = 3'b000, NODE_INIT = 3'b001, NODE_STOPPED = 3'b010,
        NODE_OPERATIONAL = 3'b011, NODE_PREOP = 3'b100
    } cfcs_node_type;
    typedef enum logic [2:0] {
        DN_OFFLINE = 3'b000, DN_ONLINE = 3'b001, DN_CONNECTED = 3'b010,
        DN_TIMEOUT = 3'b011, DN_LINK_FAIL = 3'b100, DN_AUTOBAUD = 3'b101
    } cfcs_dnet_type;
    // Protocol selection as seen by this block
    typedef enum logic [1:0] {
        PROTO_NONE = 2'b00, PROTO_CAN = 2'b01, PROTO_CANOPEN = 2'b10, PROTO_DNET = 2'b11
    } cfcs_proto_type;
endpackage : cfcs_pkg
`default_nettype wire

// file: cfcs_status_props.sv
// Checker: port properties of the CAN fieldbus command and status block
`default_nettype none
module cfcs_status_props
    import cfcs_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic canCmdWrite,
    input wire logic [7:0] canCmdData,
    input wire logic otherCmdWrite,
    input wire logic [1:0] canProtocolSelect,
    input wire logic noBusPower,
    input wire logic busOff,
    input wire logic frameReceived,
    input wire logic [7:0] fieldbusCommandWord,
    input wire logic [15:0] fieldbusSpeedReference,
    input wire logic [2:0] controllerStatus,
    input wire logic [CNT_W-1:0] rxFrameCount,
    input wire logic [CNT_W-1:0] busOffCount,
    input wire logic faultResetPulse
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    cmd_load_a: assert property (
        canCmdWrite |=> fieldbusCommandWord == $past(canCmdData)) else $error("cmd load");
    foreign_write_a: assert property (
        otherCmdWrite && !canCmdWrite |=> $stable(fieldbusCommandWord)) else $error("foreign");
    rx_count_a: assert property (
        1'h1 |=> rxFrameCount == CNT_W'($past(rxFrameCount) + $past(frameReceived)))
        else $error("rx count");
    bus_off_count_a: assert property (
        $rose(busOff) |=> busOffCount == CNT_W'($past(busOffCount) + 1'b1))
        else $error("bus off count");
    no_protocol_a: assert property (
        canProtocolSelect == PROTO_NONE |=> controllerStatus == CTL_DISABLED)
        else $error("no protocol status");
    no_power_a: assert property (
        canProtocolSelect != PROTO_NONE && noBusPower |=> controllerStatus == CTL_NO_POWER)
        else $error("no power status");
    fault_pulse_a: assert property (
        faultResetPulse |=> !faultResetPulse) else $error("fault pulse too long");
    speed_range_a: assert property (
        $signed(fieldbusSpeedReference) <= SPEED_MAX
        && $signed(fieldbusSpeedReference) >= SPEED_MIN) else $error("speed range");
endmodule : cfcs_status_props
bind cfcs_can_fieldbus_command_status cfcs_status_props #(.CNT_W(CNT_W)) u_props (.*);
`default_nettype wire

// file: cfcs_can_master.sv
// Partner: CAN network master issuing register writes and frame events
`default_nettype none
module cfcs_can_master (
    input wire logic mclk,
    output logic canCmdWrite,
    output logic [7:0] canCmdData,
    output logic canSpeedWrite,
    output logic [15:0] canSpeedData,
    output logic frameReceived,
    output logic frameTransmitted,
    output logic frameLost
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {canCmdWrite, canCmdData, canSpeedWrite, canSpeedData, frameReceived,
        frameTransmitted, frameLost} = '0;
    // Lost frames come only when asked; their pace is the integrator's choice
    task automatic send(input logic [4:0] pulses, input logic [23:0] dat);
        @(posedge mclk);
        {canCmdWrite, canSpeedWrite, frameReceived, frameTransmitted, frameLost} <= pulses;
        {canCmdData, canSpeedData} <= dat;
        @(posedge mclk);
        {canCmdWrite, canSpeedWrite, frameReceived, frameTransmitted, frameLost} <= 5'h00;
        // Released data shows the inverse so a late sample cannot match by luck
        {canCmdData, canSpeedData} <= ~dat;
    endtask : send
endmodule : cfcs_can_master
`default_nettype wire

// file: can_fieldbus_command_status_test.sv
// Testbench: random and corner stimulus for the CAN fieldbus command block
`default_nettype none
module can_fieldbus_command_status_test
    import cfcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CW = 4;
    logic mclk, resetn, canCmdWrite, canSpeedWrite, otherCmdWrite, otherSpeedWrite, hit, p7, pBo;
    logic commandSourceIsCan, referenceSourceIsCan, directionCommandBitSource, autobaudRunning;
    logic warningLevel, errorPassive, busOff, noBusPower, frameReceived, frameTransmitted;
    logic frameLost, coErrorControl, coGuardError, coHeartbeatError, dnOnline, dnConnected;
    logic dnTimedOut, dnLinkFailure, rampEnable, generalEnable, runReverse, inchingRun;
    logic remoteSetSelect, secondRampSelect, quickStopDisable, faultResetPulse, motorForward;
    logic [1:0] canProtocolSelect;
    logic [2:0] coNodeStateIn, controllerStatus, canopenCommStatus, canopenNodeState;
    logic [2:0] devicenetStatus;
    logic [7:0] canCmdData, fieldbusCommandWord, d;
    logic [15:0] canSpeedData, otherWriteData, fieldbusSpeedReference, activeSpeedReference;
    logic [15:0] seed, v, sp;
    logic [16:0] st, s;
    logic [CW-1:0] rxFrameCount, txFrameCount, busOffCount, lostMessageCount, eRx, eTx, eBo, eL;
    logic [7:0] cmdCorner [4] = '{8'h80, 8'h00, 8'h80, 8'h7F};
    logic [15:0] spdCorner [5] = '{16'h4E20, 16'hB1E0, 16'h7FFF, 16'h8000, 16'h0000};
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    wire logic [6:0] cmdBits = {quickStopDisable, secondRampSelect, remoteSetSelect, inchingRun,
        runReverse, generalEnable, rampEnable};
    cfcs_can_fieldbus_command_status #(.CNT_W(CW)) DUT (.*);
    cfcs_can_master u_master (.*);
    assign {autobaudRunning, warningLevel, errorPassive, busOff, noBusPower, coErrorControl,
        coGuardError, coHeartbeatError, dnOnline, dnConnected, dnTimedOut, dnLinkFailure,
        coNodeStateIn, canProtocolSelect} = st;
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    function automatic logic [2:0] exp_ctl(input logic [16:0] x);
        return x[1:0] == PROTO_NONE ? CTL_DISABLED : x[12] ? CTL_NO_POWER : x[13] ? CTL_BUS_OFF
            : x[14] ? CTL_PASSIVE : x[15] ? CTL_WARNING
            : x[16] && x[1:0] == PROTO_DNET ? CTL_AUTOBAUD : CTL_ACTIVE;
    endfunction : exp_ctl
    function automatic logic [2:0] exp_dn(input logic [16:0] x);
        return x[16] ? DN_AUTOBAUD : x[5] | x[13] ? DN_LINK_FAIL : x[6] ? DN_TIMEOUT
            : x[7] ? DN_CONNECTED : x[8] ? DN_ONLINE : DN_OFFLINE;
    endfunction : exp_dn
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic print_verdict;
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end
    // Whole run needs under a thousand cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        {resetn, otherCmdWrite, otherSpeedWrite, otherWriteData, st, hit} = '0;
        {commandSourceIsCan, referenceSourceIsCan, directionCommandBitSource} = '0;
        {seed, sp, p7, pBo, eRx, eTx, eBo, eL} = {16'h62B2, 34'h0};
        repeat (4) @(posedge mclk);
        resetn <= 1'h1;
        @(negedge mclk);
        chk("reset", 32'h1, {fieldbusCommandWord, rxFrameCount, motorForward});
        u_master.send(5'h10, 24'hFF0000);
        @(posedge mclk);
        @(negedge mclk);
        chk("gated", 32'h3FC, {fieldbusCommandWord, generalEnable, faultResetPulse});
        @(posedge mclk) commandSourceIsCan <= 1'h1;
        repeat (3) @(negedge mclk) hit |= faultResetPulse;
        chk("source pulse", 32'h1, hit);
        p7 = 1'h1;
        for (int i = 0; i < 24; i++) begin
            d = i < 4 ? cmdCorner[i] : seed[7:0];
            v = i < 5 ? spdCorner[i] : seed;
            u_master.send(5'h08, {8'h00, v});
            u_master.send(5'h10, {d, 16'h0000});
            sp = $signed(v) > SPEED_MAX ? SPEED_MAX : $signed(v) < SPEED_MIN ? SPEED_MIN : v;
            // Foreign writes follow the CAN ones, so an accepted one would show
            @(posedge mclk) {otherCmdWrite, otherSpeedWrite, otherWriteData} <= {2'h3, ~seed};
            {referenceSourceIsCan, directionCommandBitSource} <= seed[9:8];
            @(negedge mclk);
            chk("bits", d[6:0], cmdBits);
            chk("pulse", d[7] & !p7, faultResetPulse);
            @(posedge mclk) {otherCmdWrite, otherSpeedWrite} <= 2'h0;
            @(posedge mclk);
            @(negedge mclk);
            chk("word", d, fieldbusCommandWord);
            chk("speed", sp, fieldbusSpeedReference);
            chk("active", referenceSourceIsCan ? sp : 16'h0, activeSpeedReference);
            if (referenceSourceIsCan && sp != 16'h0)
                chk("dir", directionCommandBitSource == ($signed(sp) > 0), motorForward);
            {p7, seed} = {d[7], lfsr(seed)};
        end
        for (int i = 0; i < 40; i++) begin
            u_master.send({2'h0, seed[2:0]}, 24'h0);
            {eRx, eTx, eL} = {eRx + seed[2], eTx + seed[1], eL + seed[0]};
            @(negedge mclk);
            chk("rx", eRx, rxFrameCount);
            chk("tx", eTx, txFrameCount);
            chk("lost", eL, lostMessageCount);
            seed = lfsr(seed);
        end
        for (int i = 0; i < 200; i++) begin
            s = i == 0 ? 17'h10003 : {seed[0], seed};
            @(posedge mclk) st <= s;
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            {eBo, pBo} = {eBo + (s[13] & !pBo), s[13]};
            chk("ctl", exp_ctl(s), controllerStatus);
            chk("bus off", eBo, busOffCount);
            if (s[1:0] == PROTO_CANOPEN) begin
                v = s[9] ? CO_HEART_ERR : s[10] ? CO_GUARD_ERR
                    : s[11] ? CO_ERR_CTRL : CO_ENABLED;
                chk("co", v, canopenCommStatus);
                chk("node", s[4:2] > 3'h4 ? 3'h0 : s[4:2], canopenNodeState);
            end
            if (s[1:0] == PROTO_DNET)
                chk("dn", exp_dn(s), devicenetStatus);
            seed = lfsr(seed);
        end
        print_verdict();
    end
endmodule : can_fieldbus_command_status_test
`default_nettype wire
